//--- design/slcr_defines.vh
`ifndef SLCR_DEFINES_VH
`define SLCR_DEFINES_VH
// --------------------------------------------------------------------------
// Overview of operation
// - enable bit0: 0 off, 1 on, resets 1
// - disabled: link reset, serializers down, clocks gated
// - disabled: multiframe counter reset, sysref ignored
// - mode code bits 5:0, bits 7:6 reserved
// - frames per multiframe minus one, resets 31
// - 64b66b modes use 256*E/F, register ignored
// - manual bit 0 requests resync, resets 1
// - manual request works under any source select
// - stuck pin released by source select 2 or 3, neither watches a pin
// - control: lanes b4, source b3:2, format b1, scramble b0
// - source 0 sync pin, 1 timestamp pin, 2 none
// - upper mapping uses lanes 4 to 4+L-1
// - format 0 offset binary, 1 twos complement
// - scramble bit only in 8b10b, 64b66b always
// --------------------------------------------------------------------------

// register indices; byte address is four times the index
`define SLCR_IDX_ENABLE   10'h200
`define SLCR_IDX_MODE     10'h201
`define SLCR_IDX_KM1      10'h202
`define SLCR_IDX_RESYNC   10'h203
`define SLCR_IDX_CTRL     10'h204
`define SLCR_IDX_EFF_K    10'h20E
`define SLCR_IDX_STATUS   10'h20F

// field positions
`define SLCR_CTRL_UPPER   4
`define SLCR_CTRL_SRC_HI  3
`define SLCR_CTRL_SRC_LO  2
`define SLCR_CTRL_FORMAT  1
`define SLCR_CTRL_RAND    0

// reset values
`define SLCR_RST_ENABLE   1'h1
`define SLCR_RST_MODE     6'h00
`define SLCR_RST_KM1      8'h1F
`define SLCR_RST_RESYNC   1'h1
`define SLCR_RST_CTRL     5'h03

// sync source codes
`define SLCR_SRC_SYNC_PIN 2'h0
`define SLCR_SRC_TS_PIN   2'h1
`define SLCR_SRC_NONE     2'h2

// link geometry
`define SLCR_LANES        8
`define SLCR_UPPER_BASE   4
`define SLCR_EXT_BLOCK    10'h100
`endif

//--- design/slcr_link_regs.v
`timescale 1ns/100ps
`include "slcr_defines.vh"

module slcr_link_regs (
    // clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // avalon-mm slave
    input  wire [11:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // mode table lookups for the current mode code
    input  wire        mode_uses_64b66b,
    input  wire [3:0]  mode_e,
    input  wire [4:0]  mode_f,
    input  wire [3:0]  mode_lane_count,
    // sync pins, active low, asynchronous; the timestamp receiver enable is active high
    input  wire        dedicated_resync_input_pin,
    input  wire        timestamp_input_pin,
    input  wire        timestamp_receiver_enable,
    // link control outputs
    output reg         link_logic_reset,
    output reg         serializer_power_down,
    output reg         link_clock_enable,
    output reg         multiframe_counter_reset,
    output reg         sysref_align_enable,
    output reg         link_resync_request,
    output reg  [5:0]  output_mode_code,
    output reg  [9:0]  effective_k_minus_one,
    output reg         upper_lane_mapping,
    output reg         sample_format,
    output reg         payload_randomizer_active,
    output reg  [7:0]  lane_enable
);

// --------------------------------------------------------------------------
// register storage
// --------------------------------------------------------------------------
reg        link_enable;
reg  [5:0] mode_code;
reg  [7:0] frames_per_multiframe_minus_one;
reg        manual_resync_request_low;
reg  [4:0] link_control;

wire [9:0] word_index = avs_address[11:2];
wire       bus_take   = avs_write && !avs_waitrequest;

// --------------------------------------------------------------------------
// sync pin synchronisers
// --------------------------------------------------------------------------
// three stages; the filtered level only moves when stages two and three
// agree, so a single metastable sample cannot flip it
wire [1:0] pin_raw = {timestamp_input_pin, dedicated_resync_input_pin};
reg  [1:0] pin_s1;
reg  [1:0] pin_s2;
reg  [1:0] pin_s3;
reg  [1:0] pin_level;

genvar gp;
generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_pin
        always @(posedge core_clk) begin
            if (!reset_n) begin
                pin_s1[gp]    <= 1'h1;
                pin_s2[gp]    <= 1'h1;
                pin_s3[gp]    <= 1'h1;
                pin_level[gp] <= 1'h1;
            end else begin
                pin_s1[gp] <= pin_raw[gp];
                pin_s2[gp] <= pin_s1[gp];
                pin_s3[gp] <= pin_s2[gp];
                if (pin_s2[gp] == pin_s3[gp]) begin
                    pin_level[gp] <= pin_s3[gp];
                end
            end
        end
    end
endgenerate

// --------------------------------------------------------------------------
// decoding helpers
// --------------------------------------------------------------------------
// lane is in use for the given mapping and lane count
function lane_used;
    input [3:0] lane;
    input       upper;
    input [3:0] count;
    reg   [4:0] base;
    begin
        base      = upper ? 5'h04 : 5'h00;
        lane_used = ({1'h0, lane} >= base) &&
                    ({1'h0, lane} < (base + {1'h0, count}));
    end
endfunction

// effective frames per multiframe minus one, 64b66b uses 256*E/F
function [9:0] eff_k;
    input       ext;
    input [7:0] km1;
    input [3:0] e;
    input [4:0] f;
    reg  [13:0] prod;
    reg  [13:0] quot;
    begin
        prod = {4'h0, `SLCR_EXT_BLOCK} * {10'h000, e};
        quot = (f == 5'h00) ? 14'h0000 : prod / {9'h000, f};
        if (ext) begin
            eff_k = (quot == 14'h0000) ? 10'h000 :
                    quot[9:0] - 10'h001;
        end else begin
            eff_k = {2'h0, km1};
        end
    end
endfunction

// --------------------------------------------------------------------------
// register writes
// --------------------------------------------------------------------------
// reserved bits are not stored and read back as zero; ordering against
// calibration and link enable is left to software
always @(posedge core_clk) begin
    if (!reset_n) begin
        link_enable                     <= `SLCR_RST_ENABLE;
        mode_code                       <= `SLCR_RST_MODE;
        frames_per_multiframe_minus_one <= `SLCR_RST_KM1;
        manual_resync_request_low       <= `SLCR_RST_RESYNC;
        link_control                    <= `SLCR_RST_CTRL;
    end else if (bus_take) begin
        case (word_index)
            `SLCR_IDX_ENABLE: begin
                link_enable <= avs_writedata[0];
            end
            `SLCR_IDX_MODE: begin
                mode_code <= avs_writedata[5:0];
            end
            `SLCR_IDX_KM1: begin
                frames_per_multiframe_minus_one <= avs_writedata[7:0];
            end
            `SLCR_IDX_RESYNC: begin
                manual_resync_request_low <= avs_writedata[0];
            end
            `SLCR_IDX_CTRL: begin
                link_control <= avs_writedata[4:0];
            end
            default: begin
                link_enable <= link_enable;
            end
        endcase
    end
end

// --------------------------------------------------------------------------
// bus answer
// --------------------------------------------------------------------------
// one wait state: the request is seen with waitrequest high, read data is
// captured and waitrequest drops, the master completes on the next edge
reg [31:0] next_readdata;

always @* begin
    next_readdata = 32'h0000_0000;
    case (word_index)
        `SLCR_IDX_ENABLE: begin
            next_readdata = {31'h0, link_enable};
        end
        `SLCR_IDX_MODE: begin
            next_readdata = {26'h0, mode_code};
        end
        `SLCR_IDX_KM1: begin
            next_readdata = {24'h0, frames_per_multiframe_minus_one};
        end
        `SLCR_IDX_RESYNC: begin
            next_readdata = {31'h0, manual_resync_request_low};
        end
        `SLCR_IDX_CTRL: begin
            next_readdata = {27'h0, link_control};
        end
        `SLCR_IDX_EFF_K: begin
            next_readdata = {22'h0, effective_k_minus_one};
        end
        // status: synced pins, wide layer, clock enable, request
        `SLCR_IDX_STATUS: begin
            next_readdata = {27'h0, pin_level, mode_uses_64b66b,
                             link_clock_enable, link_resync_request};
        end
        default: begin
            next_readdata = 32'h0000_0000;
        end
    endcase
end

always @(posedge core_clk) begin
    if (!reset_n) begin
        avs_waitrequest <= 1'h1;
        avs_readdata    <= 32'h0000_0000;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
        avs_waitrequest <= 1'h0;
        avs_readdata    <= avs_read ? next_readdata : avs_readdata;
    end else begin
        avs_waitrequest <= 1'h1;
    end
end

// --------------------------------------------------------------------------
// link control
// --------------------------------------------------------------------------
wire [1:0] sync_source = link_control[`SLCR_CTRL_SRC_HI:`SLCR_CTRL_SRC_LO];
reg        pin_request;

always @* begin
    case (sync_source)
        `SLCR_SRC_SYNC_PIN: begin
            pin_request = !pin_level[0];
        end
        `SLCR_SRC_TS_PIN: begin
            // the timestamp pin counts only with its receiver on
            pin_request = timestamp_receiver_enable && !pin_level[1];
        end
        `SLCR_SRC_NONE: begin
            // no pin is watched, same as the unlisted code 3 below
            pin_request = 1'h0;
        end
        default: begin
            pin_request = 1'h0;
        end
    endcase
end

wire [9:0] next_eff_k = eff_k(mode_uses_64b66b,
                              frames_per_multiframe_minus_one,
                              mode_e, mode_f);

// --------------------------------------------------------------------------
// link enable effects
// --------------------------------------------------------------------------
// everything behind the link is held while the enable bit is low, so
// sysref cannot move the multiframe counter in that time
always @(posedge core_clk) begin
    if (!reset_n) begin
        link_logic_reset         <= 1'h0;
        serializer_power_down    <= 1'h0;
        link_clock_enable        <= 1'h1;
        multiframe_counter_reset <= 1'h0;
        sysref_align_enable      <= 1'h1;
    end else begin
        link_logic_reset         <= !link_enable;
        serializer_power_down    <= !link_enable;
        link_clock_enable        <= link_enable;
        multiframe_counter_reset <= !link_enable;
        sysref_align_enable      <= link_enable;
    end
end

// --------------------------------------------------------------------------
// resynchronisation request
// --------------------------------------------------------------------------
always @(posedge core_clk) begin
    if (!reset_n) begin
        link_resync_request <= 1'h0;
    end else begin
        // manual request acts under every source select
        link_resync_request <= pin_request ||
                               !manual_resync_request_low;
    end
end

// --------------------------------------------------------------------------
// configuration outputs
// --------------------------------------------------------------------------
always @(posedge core_clk) begin
    if (!reset_n) begin
        output_mode_code          <= `SLCR_RST_MODE;
        effective_k_minus_one     <= {2'h0, `SLCR_RST_KM1};
        upper_lane_mapping        <= 1'h0;
        sample_format             <= 1'h1;
        payload_randomizer_active <= 1'h1;
    end else begin
        output_mode_code          <= mode_code;
        effective_k_minus_one     <= next_eff_k;
        upper_lane_mapping        <= link_control[`SLCR_CTRL_UPPER];
        sample_format             <= link_control[`SLCR_CTRL_FORMAT];
        payload_randomizer_active <= mode_uses_64b66b ||
                                     link_control[`SLCR_CTRL_RAND];
    end
end

// --------------------------------------------------------------------------
// lane enables
// --------------------------------------------------------------------------
// upper mapping with more than four lanes is undefined; lanes past the
// last physical lane are simply dropped
genvar gl;
generate
    for (gl = 0; gl < `SLCR_LANES; gl = gl + 1) begin : g_lane
        localparam integer lane_i = gl;
        always @(posedge core_clk) begin
            if (!reset_n) begin
                lane_enable[gl] <= 1'h0;
            end else begin
                lane_enable[gl] <= link_enable &&
                    lane_used(lane_i[3:0], link_control[`SLCR_CTRL_UPPER],
                              mode_lane_count);
            end
        end
    end
endgenerate

endmodule

//--- tb/slcr_chk_props.sv
`timescale 1ns/100ps
module slcr_chk (
    // clock and reset
    input wire        core_clk,
    input wire        reset_n,
    // register bus
    input wire [11:0] avs_address,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    // link side
    input wire        mode_uses_64b66b,
    input wire        link_logic_reset,
    input wire        serializer_power_down,
    input wire        link_clock_enable,
    input wire        multiframe_counter_reset,
    input wire        sysref_align_enable,
    input wire        link_resync_request,
    input wire [5:0]  output_mode_code,
    input wire        sample_format,
    input wire        payload_randomizer_active,
    input wire [7:0]  lane_enable
);
    // --------
    // properties
    // --------
    // a write lands at the edge where waitrequest is seen low
    wire       wr = avs_write && !avs_waitrequest;
    wire [9:0] ix = avs_address[11:2];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_enable_write: assert property (wr && ix == 10'h200 |-> ##2
        link_clock_enable == $past(avs_writedata[0], 2)) else $error("en");
    a_disabled_gating: assert property (link_logic_reset |->
        serializer_power_down && !link_clock_enable) else $error("gate");
    a_lanes_off: assert property (link_logic_reset |->
        lane_enable == 8'h00) else $error("lanes");
    a_counter_held: assert property (!sysref_align_enable ==
        link_logic_reset && multiframe_counter_reset == link_logic_reset)
        else $error("counter");
    a_mode_copy: assert property (wr && ix == 10'h201 |-> ##2
        output_mode_code == $past(avs_writedata[5:0], 2)) else $error("mode");
    a_format_copy: assert property (wr && ix == 10'h204 |-> ##2
        sample_format == $past(avs_writedata[1], 2)) else $error("format");
    a_wide_scramble: assert property ($past(mode_uses_64b66b) |->
        payload_randomizer_active) else $error("scramble");
    a_manual_resync: assert property (wr && ix == 10'h203 &&
        !avs_writedata[0] |-> ##[1:3] link_resync_request)
        else $error("resync");
    c_disable: cover property (wr && ix == 10'h200 && !avs_writedata[0]);
    c_resync: cover property (link_resync_request);
    c_wide: cover property (mode_uses_64b66b && payload_randomizer_active);
endmodule

bind slcr_link_regs slcr_chk u_chk (.*);

//--- tb/slcr_rx_model.sv
`timescale 1ns/100ps
module slcr_rx_model (
    // bench control
    input  wire core_clk,
    input  wire want_sync,
    input  wire use_ts,
    // sync pins, active low
    output reg  dedicated_resync_input_pin = 1'b1,
    output reg  timestamp_input_pin = 1'b1
);
    // the receiver pulls one pin low; the unused one idles high
    always @(posedge core_clk) begin
        dedicated_resync_input_pin <= !(want_sync && !use_ts);
        timestamp_input_pin <= !(want_sync && use_ts);
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    // --------
    // signals
    // --------
    logic        core_clk, avs_waitrequest, timestamp_input_pin;
    logic        dedicated_resync_input_pin, link_resync_request;
    logic        reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        mode_uses_64b66b = 1'b0, timestamp_receiver_enable = 1'b0;
    logic [3:0]  mode_e = 4'h1, mode_lane_count = 4'h1;
    logic [4:0]  mode_f = 5'h01;
    logic        want_sync = 1'b0, use_ts = 1'b0, link_logic_reset;
    logic        serializer_power_down, link_clock_enable, sample_format;
    logic        multiframe_counter_reset, sysref_align_enable;
    logic        upper_lane_mapping, payload_randomizer_active;
    logic [5:0]  output_mode_code;
    logic [9:0]  effective_k_minus_one;
    logic [7:0]  lane_enable;
    int          miscompares, n_checks, cycles, l, st, ek;
    int          mreg[5] = '{1, 0, 31, 1, 3};
    int          mask[5] = '{1, 63, 255, 1, 31};
    // source, manual bit, pin low, timestamp pin, receiver, expected
    bit   [6:0]  step[8] = '{7'h19, 7'h10, 7'h58, 7'h49, 7'h3C, 7'h3F,
                           7'h01, 7'h78};
    bit   [31:0] seed = 32'h2AC2, r, c;

    slcr_link_regs dut (.*);
    slcr_rx_model far_end (.*);

    task automatic summarize();
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // the request stands until waitrequest is seen low
    task automatic bus(input bit rd, input [9:0] ix, input [31:0] d);
        int e;
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= {ix, 2'b00};
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
        e = ix == 10'h20F ? st : (ix == 10'h20E ? ek : 0);
        if (!rd)
            mreg[ix[2:0]] = d & mask[ix[2:0]];
        else
            chk("reg", q, ix < 10'h205 ? mreg[ix[2:0]] : e);
    endtask

    initial begin
        core_clk = 1'b0;
        forever
            #2.5 core_clk = !core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        // the sixth index is unmapped and must read zero
        for (int i = 0; i < 6; i++)
            bus(1'b1, 10'h200 + 10'(i), 32'h0);
        bus(1'b0, 10'h200, 32'h0);
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            c = {27'h0, r[20], k[1:0], r[17:16]};
            // upper lanes only for four lanes or fewer
            l = r[20] ? 1 + r[25:24] : 1 + r[26:24];
            mode_uses_64b66b <= k[0];
            mode_e <= 4'h1 + r[27:26];
            mode_f <= 5'h01 + r[30:28];
            mode_lane_count <= l[3:0];
            bus(1'b0, 10'h201, {26'h0, r[5:0]});
            bus(1'b0, 10'h202, {24'h0, r[15:8]});
            bus(1'b0, 10'h204, c);
            for (int i = 0; i < 5; i++)
                bus(1'b1, 10'h200 + 10'(i), 32'h0);
            ek = k[0] ? 256 * (1 + r[27:26]) / (1 + r[30:28]) - 1 : r[15:8];
            chk("k", effective_k_minus_one, ek);
            bus(1'b1, 10'h20E, 32'h0);
            chk("upper", upper_lane_mapping, c[4]);
            chk("scr", payload_randomizer_active, c[0] | k[0]);
            bus(1'b0, 10'h200, 32'h1);
            repeat (3) @(posedge core_clk);
            chk("lanes", lane_enable, ((1 << l) - 1) << (4 * c[4]));
            bus(1'b0, 10'h200, 32'h0);
        end
        foreach (step[s]) begin
            c = step[s];
            bus(1'b0, 10'h200, 32'h0);
            bus(1'b0, 10'h204, {28'h0, c[6:5], 2'b11});
            bus(1'b0, 10'h203, {31'h0, c[4]});
            bus(1'b0, 10'h200, 32'h1);
            want_sync <= c[3];
            use_ts <= c[2];
            timestamp_receiver_enable <= c[1];
            repeat (10) @(posedge core_clk);
            chk("sync", link_resync_request, c[0]);
            st = {27'h0, !(c[3] && c[2]), !(c[3] && !c[2]),
                  mode_uses_64b66b, 1'b1, c[0]};
            bus(1'b1, 10'h20F, 32'h0);
        end
        summarize();
    end
endmodule
